// >>> csbp_port.v
`timescale 1ns/10ps
`include "csbp_map.vh"
module csbp_port #(
   parameter BLOCK_BYTES = 8
)(
   input  wire        clk,
   input  wire        srst,
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output reg         irq,
   input  wire [7:0]  secondary_byte_bus_in,
   output reg  [7:0]  secondary_byte_bus_out,
   output reg         secondary_byte_bus_oe,
   input  wire        secondary_port_select_n,
   input  wire        secondary_port_strobe_n,
   output reg         secondary_port_flag_n
);

localparam CW = 4;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers: select/strobe three stages, change taken when stages 2 and 3 agree; byte bus two stages
reg  [2:0] cs_sync_q;
reg  [2:0] ds_sync_q;
reg  [7:0] bus_s1_q;
reg  [7:0] bus_s2_q;
reg        cs_q;
reg        ds_q;
reg        xfer_q;
wire       xfer_d;

always @(posedge clk)
begin
   if (srst)
   begin
      cs_sync_q <= 3'h7;
      ds_sync_q <= 3'h7;
      bus_s1_q  <= 8'h00;
      bus_s2_q  <= 8'h00;
      cs_q      <= 1'b1;
      ds_q      <= 1'b1;
      xfer_q    <= 1'b0;
   end
   else
   begin
      // Select is only sampled, never held across strobes
      cs_sync_q <= {cs_sync_q[1:0], secondary_port_select_n};
      ds_sync_q <= {ds_sync_q[1:0], secondary_port_strobe_n};
      bus_s1_q  <= secondary_byte_bus_in;
      bus_s2_q  <= bus_s1_q;
      if (cs_sync_q[1] == cs_sync_q[2])
         cs_q <= cs_sync_q[2];
      if (ds_sync_q[1] == ds_sync_q[2])
         ds_q <= ds_sync_q[2];
      xfer_q <= xfer_d;
   end
end

// Transfer only while both low together
assign xfer_d = ~cs_q & ~ds_q;
wire xfer_start = xfer_d & ~xfer_q;

////////////////////////////////////////////////////////////////////////
// Control and register state
reg  [2:0]  ctrl_q;
reg  [CW-1:0] in_cnt_q;
reg  [CW-1:0] out_cnt_q;
reg  [7:0]  in_buf_q  [0:BLOCK_BYTES-1];
reg  [7:0]  out_buf_q [0:BLOCK_BYTES-1];
reg  [`CSBP_EV_W-1:0] ev_stat_q;
reg  [`CSBP_EV_W-1:0] ev_mask_q;

wire dual_mode  = ctrl_q[`CSBP_CTRL_DUAL];
// Direction from control bit; single port always outputs here
wire dir_out    = ctrl_q[`CSBP_CTRL_DIR_OUT] | ~dual_mode;
wire running    = ctrl_q[`CSBP_CTRL_RUN];
wire in_full    = (in_cnt_q == BLOCK_BYTES[CW-1:0]);
wire out_empty  = (out_cnt_q == {CW{1'b0}});

reg  flag_d;
always @*
begin
   // Flag source chosen by control bits
   if (!running)
      flag_d = 1'b0;
   else if (!dual_mode)
      flag_d = ~out_empty;
   else if (!dir_out)
      flag_d = ~in_full;
   else
      flag_d = ~out_empty;
end

wire take_in  = xfer_start & ~dir_out & secondary_port_flag_n == 1'b0;
wire give_out = xfer_start & dir_out & secondary_port_flag_n == 1'b0;
wire bad_xfer = xfer_start & secondary_port_flag_n;

////////////////////////////////////////////////////////////////////////
// AHB-Lite slave, zero wait states
reg        ph_wr_q;
reg  [7:0] ph_addr_q;
wire       ph_go = hsel & hready & (htrans == `CSBP_HTRANS_NONSEQ);
// Read data is captured at the address phase so it stands in the data phase
wire       rd_go  = ph_go & ~hwrite;
wire       wr_in  = ph_wr_q & (ph_addr_q == `CSBP_IN_DATA_ADDR);

// Software pops one byte per read of any size and pushes one byte per word write, in bits 7:0
wire       sw_fill = wr_in & ~running;
wire       sw_load = ph_wr_q & (ph_addr_q == `CSBP_OUT_DATA_ADDR) & ~running;

reg  [31:0] rdata_d;
always @*
begin
   if (haddr == `CSBP_CTRL_ADDR)
      rdata_d = {29'h0000000, ctrl_q};
   else if (haddr == `CSBP_STATUS_ADDR)
      rdata_d = {15'h0000, ~secondary_port_flag_n, 4'h0, out_cnt_q,
                 4'h0, in_cnt_q};
   else if (haddr == `CSBP_IRQ_STAT_ADDR)
      rdata_d = {29'h0000000, ev_stat_q};
   else if (haddr == `CSBP_IRQ_MASK_ADDR)
      rdata_d = {29'h0000000, ev_mask_q};
   else if (haddr == `CSBP_IN_DATA_ADDR)
      rdata_d = {24'h000000, in_buf_q[0]};
   else
      rdata_d = 32'h00000000;
end

integer i;
always @(posedge clk)
begin
   if (srst)
   begin
      ph_wr_q   <= 1'b0;
      ph_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      ctrl_q    <= `CSBP_CTRL_RST;
      ev_mask_q <= 3'h0;
   end
   else
   begin
      ph_wr_q   <= ph_go & hwrite & (hsize == `CSBP_HSIZE_WORD);
      if (ph_go)
         ph_addr_q <= haddr;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_go)
         hrdata <= rdata_d;
      if (ph_wr_q && ph_addr_q == `CSBP_CTRL_ADDR)
         ctrl_q <= hwdata[2:0];
      else if (ph_wr_q && ph_addr_q == `CSBP_IRQ_MASK_ADDR)
         ev_mask_q <= hwdata[`CSBP_EV_W-1:0];
   end
end

////////////////////////////////////////////////////////////////////////
// Byte registers: index 0 is always the next byte (MSB side)
always @(posedge clk)
begin
   if (srst)
   begin
      in_cnt_q  <= {CW{1'b0}};
      out_cnt_q <= {CW{1'b0}};
      for (i = 0; i < BLOCK_BYTES; i = i + 1)
      begin
         in_buf_q[i]  <= 8'h00;
         out_buf_q[i] <= 8'h00;
      end
   end
   else
   begin
      if (take_in)
      begin
         // Bit 0 of the pins lands in bit 0 of the byte
         in_buf_q[in_cnt_q[CW-2:0]] <= bus_s2_q;
         in_cnt_q <= in_cnt_q + 1'b1;
      end
      else if (rd_go && haddr == `CSBP_IN_DATA_ADDR && in_cnt_q != 0)
      begin
         for (i = 0; i < BLOCK_BYTES - 1; i = i + 1)
            in_buf_q[i] <= in_buf_q[i+1];
         in_cnt_q <= in_cnt_q - 1'b1;
      end
      else if (sw_fill)
         in_cnt_q <= {CW{1'b0}};
      if (give_out)
      begin
         for (i = 0; i < BLOCK_BYTES - 1; i = i + 1)
            out_buf_q[i] <= out_buf_q[i+1];
         out_cnt_q <= out_cnt_q - 1'b1;
      end
      else if (sw_load && !(out_cnt_q == BLOCK_BYTES[CW-1:0]))
      begin
         out_buf_q[out_cnt_q[CW-2:0]] <= hwdata[7:0];
         out_cnt_q <= out_cnt_q + 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Pin drivers and interrupts
wire [`CSBP_EV_W-1:0] ev_set = {bad_xfer,
                                give_out & (out_cnt_q == 1),
                                take_in & (in_cnt_q == BLOCK_BYTES - 1)};
wire [`CSBP_EV_W-1:0] ev_clr = (ph_wr_q && ph_addr_q == `CSBP_IRQ_STAT_ADDR) ?
                               hwdata[`CSBP_EV_W-1:0] : 3'h0;

always @(posedge clk)
begin
   if (srst)
   begin
      secondary_port_flag_n  <= 1'b1;
      secondary_byte_bus_out <= 8'h00;
      secondary_byte_bus_oe  <= 1'b0;
      ev_stat_q <= 3'h0;
      irq       <= 1'b0;
   end
   else
   begin
      secondary_port_flag_n  <= ~flag_d;
      secondary_byte_bus_out <= out_buf_q[0];
      // Driven only while both strobes low, flag low, output set
      secondary_byte_bus_oe  <= xfer_d & dir_out & ~secondary_port_flag_n
                                & (xfer_q ? secondary_byte_bus_oe : 1'b1);
      // Set wins over a same-cycle write-one clear
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
      irq       <= |(((ev_stat_q & ~ev_clr) | ev_set) & ev_mask_q);
   end
end

endmodule

// >>> csbp_map.vh
`ifndef CSBP_MAP_VH
`define CSBP_MAP_VH
// Register byte addresses
`define CSBP_CTRL_ADDR     8'h00
`define CSBP_STATUS_ADDR   8'h04
`define CSBP_IRQ_STAT_ADDR 8'h08
`define CSBP_IRQ_MASK_ADDR 8'h0C
`define CSBP_IN_DATA_ADDR  8'h10
`define CSBP_OUT_DATA_ADDR 8'h14
// Control fields
`define CSBP_CTRL_DUAL     0
`define CSBP_CTRL_DIR_OUT  1
`define CSBP_CTRL_RUN      2
`define CSBP_CTRL_RST      3'h0
// Status fields
`define CSBP_ST_IN_CNT_LSB 0
`define CSBP_ST_OUT_CNT_LSB 8
`define CSBP_ST_FLAG       16
// Interrupt events
`define CSBP_EV_IN_FULL    0
`define CSBP_EV_OUT_EMPTY  1
`define CSBP_EV_BAD_STROBE 2
`define CSBP_EV_W          3
// AHB codes
`define CSBP_HTRANS_NONSEQ 2'h2
`define CSBP_HSIZE_WORD    3'h2
`endif

// >>> csbp_host.sv
`timescale 1ns/10ps
module csbp_host (
   input  wire       clk,
   input  wire [7:0] dev_out,
   input  wire       dev_oe,
   input  wire       flag_n,
   output wire [7:0] bus,
   output logic      sel_n,
   output logic      stb_n
);
logic [7:0] d = 8'h00;
logic       drv = 1'b0;
initial sel_n = 1'b1;
initial stb_n = 1'b1;
// Released bus shows the inverse of the last byte, never a stale copy
assign bus = dev_oe ? dev_out : drv ? d : ~d;
////////////////////////////////////////////////////////////////
task xfer(input logic rd, s, k, input logic [7:0] w, output logic [7:0] r, output logic o);
   int n;
   o = 1'b0;
   r = 8'h00;
   // Bounded wait; a refused strobe goes ahead after the wait
   for (n = 0; flag_n !== 1'b0 && n < 200; n++) @(posedge clk);
   d <= w;
   drv <= !rd;
   sel_n <= s;
   stb_n <= 1'b0;
   repeat (8)
   begin
      @(posedge clk);
      if (dev_oe === 1'b1 && !o)
      begin
         r = dev_out;
         o = 1'b1;
      end
   end
   stb_n <= 1'b1;
   drv <= 1'b0;
   sel_n <= k;
   repeat (6) @(posedge clk);
endtask
endmodule

// >>> csbp_port_sva.sv
`timescale 1ns/10ps
module csbp_sva (
   input wire clk,
   input wire srst,
   input wire hreadyout,
   input wire hresp,
   input wire irq,
   input wire secondary_byte_bus_oe,
   input wire secondary_port_select_n,
   input wire secondary_port_strobe_n,
   input wire secondary_port_flag_n
);
wire oe = secondary_byte_bus_oe;
wire sn = secondary_port_select_n;
wire dn = secondary_port_strobe_n;
wire fn = secondary_port_flag_n;
default clocking @(posedge clk); endclocking
default disable iff (srst);
property p_cause; $rose(oe) |-> $past(!sn && !dn, 3); endproperty
a_cause: assert property (p_cause) else $error("drive without request");
property p_flag; $rose(oe) |-> $past(!fn); endproperty
a_flag: assert property (p_flag) else $error("drive with flag off");
property p_sel; sn [*6] |-> !oe; endproperty
a_sel: assert property (p_sel) else $error("drive without select");
property p_stb; dn [*6] |-> !oe; endproperty
a_stb: assert property (p_stb) else $error("drive without strobe");
property p_fall; $fell(oe) |-> $past(sn || dn, 2) || $past(fn); endproperty
a_fall: assert property (p_fall) else $error("drive dropped early");
property p_stay; (!sn && !dn) [*5] ##0 oe |=> oe || fn; endproperty
a_stay: assert property (p_stay) else $error("drive lost");
property p_rst; $fell(srst) |-> fn && !oe && !irq; endproperty
a_rst: assert property (p_rst) else $error("reset state");
property p_bus; hreadyout && !hresp; endproperty
a_bus: assert property (p_bus) else $error("bus response");
cover property ($rose(oe));
cover property ($rose(irq));
cover property ($fell(fn));
endmodule
bind csbp_port csbp_sva csbp_sva_i (.clk(clk), .srst(srst), .hreadyout(hreadyout),
   .hresp(hresp), .irq(irq), .secondary_byte_bus_oe(secondary_byte_bus_oe),
   .secondary_port_select_n(secondary_port_select_n),
   .secondary_port_strobe_n(secondary_port_strobe_n),
   .secondary_port_flag_n(secondary_port_flag_n));

// >>> tb_csbp_port.sv
`timescale 1ns/10ps
`include "csbp_map.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_csbp_port;
logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, o;
logic [7:0]  haddr = 8'h00, b;
logic [1:0]  htrans = 2'h0;
logic [31:0] hwdata = 32'h0, r;
logic [3:0]  i;
wire  [31:0] hrdata;
wire  [7:0]  bus, dout;
wire         hro, irq, oe, sn, dn, fn;
int          errors = 0, checked = 0;
always #5 clk = ~clk;
csbp_port csbp_port_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(`CSBP_HSIZE_WORD), .hwdata(hwdata), .hready(hro), .hrdata(hrdata),
   .hreadyout(hro), .hresp(), .irq(irq), .secondary_byte_bus_in(bus),
   .secondary_byte_bus_out(dout), .secondary_byte_bus_oe(oe), .secondary_port_select_n(sn),
   .secondary_port_strobe_n(dn), .secondary_port_flag_n(fn));
csbp_host csbp_host_i (.clk(clk), .dev_out(dout), .dev_oe(oe), .flag_n(fn), .bus(bus),
   .sel_n(sn), .stb_n(dn));
////////////////////////////////////////////////////////////////
task print_verdict;
   $display("checks %0d errors %0d", checked, errors);
   if (errors == 0 && checked > 0)
      $display("Finished cleanly");
   else
      $display("Finished with errors");
   $finish;
endtask
task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
   htrans <= `CSBP_HTRANS_NONSEQ;
   haddr <= a;
   hwrite <= w;
   hsel <= 1'b1;
   do @(posedge clk); while (hro !== 1'b1);
   htrans <= 2'h0;
   hwdata <= d;
   do @(posedge clk); while (hro !== 1'b1);
   r = hrdata;
   // Let the flag settle after each access
   repeat (2) @(posedge clk);
endtask
task rc(input logic [7:0] a, input logic [31:0] e);
   ahb(1'b0, a, 32'h0);
   `CHK("hrdata", e, r)
endtask
////////////////////////////////////////////////////////////////
initial
begin
   #200000;
   errors++;
   print_verdict;
end
initial
begin
   repeat (4) @(posedge clk);
   srst <= 1'b0;
   @(posedge clk);
   `CHK("flag", 1'b1, fn)
   rc(8'h1C, 32'h0);
   ahb(1'b1, `CSBP_CTRL_ADDR, 32'h5);
   ahb(1'b1, `CSBP_IRQ_MASK_ADDR, 32'h1);
   csbp_host_i.xfer(1'b0, 1'b1, 1'b1, 8'h55, b, o);
   rc(`CSBP_STATUS_ADDR, 32'h1_0000);
   for (i = 0; i < 8; i++)
   begin
      csbp_host_i.xfer(1'b0, 1'b0, 1'b1, {i, ~i}, b, o);
      `CHK("oe", 1'b0, o)
   end
   `CHK("flag", 1'b1, fn)
   `CHK("irq", 1'b1, irq)
   // Strobe while full is refused and flagged
   csbp_host_i.xfer(1'b0, 1'b0, 1'b1, 8'h00, b, o);
   rc(`CSBP_IRQ_STAT_ADDR, 32'h5);
   for (i = 0; i < 8; i++) rc(`CSBP_IN_DATA_ADDR, {i, ~i});
   ahb(1'b1, `CSBP_IRQ_STAT_ADDR, 32'h7);
   `CHK("irq", 1'b0, irq)
   $display("test input done");
   for (int m = 0; m < 2; m++)
   begin
      ahb(1'b1, `CSBP_CTRL_ADDR, m ? 32'h3 : 32'h0);
      for (i = 0; i < 3; i++) ahb(1'b1, `CSBP_OUT_DATA_ADDR, {i, ~i});
      ahb(1'b1, `CSBP_IRQ_MASK_ADDR, 32'h2);
      ahb(1'b1, `CSBP_CTRL_ADDR, m ? 32'h7 : 32'h4);
      `CHK("flag", 1'b0, fn)
      for (i = 0; i < 3; i++)
      begin
         csbp_host_i.xfer(1'b1, 1'b0, m[0], 8'h00, b, o);
         `CHK("byte", {i, ~i}, b)
         `CHK("oe", 1'b1, o)
      end
      `CHK("flag", 1'b1, fn)
      `CHK("irq", 1'b1, irq)
      ahb(1'b1, `CSBP_IRQ_STAT_ADDR, 32'h7);
      $display("test output %0d done", m);
   end
   print_verdict;
end
endmodule
